// [core/bccs_consts.svh]
/*
 Offsets, field positions, reset values and constants of the bridge capability
 register bank. Assumes inclusion by bare name from the core files.
*/
`ifndef BCCS_CONSTS_SVH
`define BCCS_CONSTS_SVH

// ----------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------
`define BCCS_OFF_UP_SPLIT       8'h88
`define BCCS_OFF_DN_SPLIT       8'h8c
`define BCCS_OFF_PWR_CAP        8'h90
`define BCCS_OFF_PWR_CSR        8'h94
`define BCCS_OFF_RSVD0          8'h98
`define BCCS_OFF_RSVD1          8'h9c
`define BCCS_OFF_SLOT_ID        8'ha0
`define BCCS_OFF_CLK_GATE       8'ha4
`define BCCS_OFF_SUBSYS_CAP     8'ha8
`define BCCS_OFF_SUBSYS_ID      8'hac
`define BCCS_OFF_EXP_CAP        8'hb0
`define BCCS_OFF_SPLIT_STAT     8'h84

// ----------------------------------------
// Reset values and fixed fields
// ----------------------------------------
`define BCCS_SPLIT_CAP          16'h0010
`define BCCS_SPLIT_LIMIT_RST    16'h0010
`define BCCS_SPLIT_NOLIMIT      16'hffff
`define BCCS_PM_ID              8'h01
`define BCCS_PM_NEXT            8'ha8
`define BCCS_PM_VERSION         3'h3
`define BCCS_AUX_CURRENT        3'h1
`define BCCS_PME_SUPPORT        5'h19
`define BCCS_PSTATE_D0          2'h0
`define BCCS_PSTATE_D3          2'h3
`define BCCS_SI_ID              8'h04
`define BCCS_SI_NEXT            8'hb0
`define BCCS_SUB_ID             8'h0d
`define BCCS_SUB_NEXT_DFLT      8'hb0
`define BCCS_SUB_NEXT_SI        8'ha0
`define BCCS_EXP_ID             8'h10
`define BCCS_EXP_NEXT           8'hf0
`define BCCS_EXP_VERSION        4'h1
`define BCCS_EXP_TYPE_FWD       4'h7
`define BCCS_EXP_TYPE_REV       4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BCCS_BIT_PME_EN         8
`define BCCS_BIT_PME_STAT       15
`define BCCS_BIT_CLK_STOPPED    13
`define BCCS_BIT_CLKRUN_EN      14
`define BCCS_BIT_CLKRUN_MODE    15
`define BCCS_BIT_SPLIT_DLY      21

// ----------------------------------------
// Timing
// ----------------------------------------
`define BCCS_CLK_PERIOD_NS      4
`define BCCS_PM_RESET_NS        40
`define BCCS_PM_RESET_CYC       (`BCCS_PM_RESET_NS / `BCCS_CLK_PERIOD_NS)

`endif

// [core/bccs_pkg.sv]
/*
 Types of the bridge capability register bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package bccs_pkg;

	typedef enum logic [1:0] {
		PM_D0     = 2'b00,
		PM_RESET  = 2'b01,
		PM_D3     = 2'b11
	} bccs_pm_e;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bccs_bus_s;

	typedef struct packed {
		logic        secIdle;
		logic        priPending;
	} bccs_busstate_s;

endpackage

// [core/bccs_clock_gate.sv]
/*
 Secondary clock output gating: per-output enables in forward mode only, and the clock-run stop.
 Assumes clockIn is a free-running secondary clock from the same core clock tree;
 gating is done with a registered enable sampled on the core clock.
*/
`timescale 1ns/10ps
`include "bccs_consts.svh"

module bccs_clock_gate (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        clockIn,
	input  wire logic        forwardMode,
	input  wire logic [10:0] gateCtl,
	input  wire logic        clockStop,
	output logic      [6:0]  clockOut
);

	logic [6:0] runEn_r;
	logic [6:0] runEn_nxt;
	integer     i;

	always_comb begin
		runEn_nxt = 7'h7f;
		if (forwardMode) begin
			for (i = 0; i < 4; i = i + 1) begin
				runEn_nxt[i] = ~(gateCtl[2*i] & gateCtl[2*i+1]);
			end
			for (i = 0; i < 3; i = i + 1) begin
				runEn_nxt[4+i] = ~gateCtl[8+i];
			end
		end
		if (clockStop) begin
			runEn_nxt = 7'h00;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			runEn_r <= 7'h7f;
		end else begin
			runEn_r <= runEn_nxt;
		end
	end

	// Stopped outputs sit low
	assign clockOut = runEn_r & {7{clockIn}};

endmodule

// [core/bccs_split_check.sv]
/*
 Commitment limit check for one direction of split requests.
 Assumes the requester holds reqValid with the pending size until it sees reqGo.
*/
`timescale 1ns/10ps
`include "bccs_consts.svh"

module bccs_split_check (
	input  wire logic [15:0] limit,
	input  wire logic [15:0] committed,
	input  wire logic [15:0] reqSize,
	input  wire logic        reqValid,
	output logic             reqGo,
	output logic             reqDelay
);

	logic [16:0] total;
	logic        fits;

	assign total    = {1'b0, committed} + {1'b0, reqSize};
	// Unlimited setting bypasses space checking
	assign fits     = (limit == `BCCS_SPLIT_NOLIMIT) || (total <= {1'b0, limit});
	assign reqGo    = reqValid & fits;
	assign reqDelay = reqValid & ~fits;

endmodule

// [core/bccs_regs.sv]
/*
 Bridge capability configuration register bank, offsets 88h to B0h, plus a
 split-status word. Assumes single-cycle strobes from a configuration master
 on the core clock; straps and bus-state inputs arrive asynchronously.
*/
// Our own choice: the plain strobed port.
//
// Notes on behaviour
// - Upstream split buffer reads 16 ADQs
// - Downstream split buffer reads 16 ADQs
// - Upstream limit writable, FFFFh disables checking
// - Downstream limit writable, FFFFh disables checking
// - Power slot_ident_cap_id 01h, next A8h
// - Version 011, no clock, no DSI, no D1/D2
// - PME support field reads 11001
// - Power state accepts only D0 and D3
// - D3 to D0 pulses internal reset only
// - PME enable bit 8 gates event output
// - PME status bit 15 write-one-clear
// - Bridge extension and data fields read zero
// - Slot ident ID 04h, next B0h, writable fields
// - Slot clocks 0-3 stop on 11 in forward mode
// - Device clocks 4-6 stop on 1 in forward mode
// - Bit 13 shows secondary clock stopped
// - Mode 0 stops clock only in D3hot
// - Mode 1 stops clock when bus idle
// - Card_code 0Dh, next B0h or A0h
// - Read-only subsystem vendor and card codes
// - Express slot_ident_cap_id 10h, next F0h
// - Port type 7h forward, 8h reverse, version 1
// - Split delayed flag set, write-one-clear
`timescale 1ns/10ps
`include "bccs_consts.svh"

module bccs_regs #(
	parameter logic [15:0] CARD_VENDOR_CODE = 16'h5a5a,  // Arbitrary value
	parameter logic [15:0] CARD_CODE        = 16'ha5a5,  // Arbitrary value
	parameter int          PM_RESET_CYC     = `BCCS_PM_RESET_CYC
) (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire bccs_pkg::bccs_bus_s    bus,
	output logic      [31:0]            rdata,
	input  wire logic                   forwardModePin,
	input  wire logic                   slotIdEnablePin,
	input  wire bccs_pkg::bccs_busstate_s busState,
	input  wire logic                   powerEvent,
	input  wire logic                   upReqValid,
	input  wire logic [15:0]            upReqSize,
	input  wire logic [15:0]            upCommitted,
	output logic                        upReqGo,
	input  wire logic                   dnReqValid,
	input  wire logic [15:0]            dnReqSize,
	input  wire logic [15:0]            dnCommitted,
	output logic                        dnReqGo,
	input  wire logic                   secClockIn,
	output logic                        slot_clock_out_0,
	output logic                        slot_clock_out_1,
	output logic                        slot_clock_out_2,
	output logic                        slot_clock_out_3,
	output logic                        device_clock_out_1,
	output logic                        device_clock_out_2,
	output logic                        bridge_feedback_clock_out,
	output logic                        power_event_out_n,
	output logic                        internalReset,
	output logic                        secBusReset,
	output logic                        clkrunEnable
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [4:0] syncA_r;
	logic [4:0] syncB_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			syncA_r <= 5'h00;
			syncB_r <= 5'h00;
		end else begin
			syncA_r <= {forwardModePin, slotIdEnablePin, busState.secIdle, busState.priPending, powerEvent};
			syncB_r <= syncA_r;
		end
	end

	logic forwardMode;
	logic slotIdEnable;
	logic secIdle;
	logic priPending;
	logic pmeEventIn;

	assign forwardMode  = syncB_r[4];
	assign slotIdEnable = syncB_r[3];
	assign secIdle      = syncB_r[2];
	assign priPending   = syncB_r[1];
	assign pmeEventIn   = syncB_r[0];

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic hitWr(input bccs_pkg::bccs_bus_s b, input logic [7:0] off);
		hitWr = b.wr && (b.addr == off);
	endfunction

	logic [31:0] w;
	assign w = bus.wdata;

	// ----------------------------------------
	// Split commitment limits and status
	// ----------------------------------------
	logic [15:0] upLimit_r;
	logic [15:0] dnLimit_r;
	logic        splitDelayed_r;
	logic        upDelay;
	logic        dnDelay;

	always_ff @(posedge clock) begin
		if (rst) begin
			upLimit_r <= `BCCS_SPLIT_LIMIT_RST;
			dnLimit_r <= `BCCS_SPLIT_LIMIT_RST;
		end else begin
			if (hitWr(bus, `BCCS_OFF_UP_SPLIT)) begin
				upLimit_r <= w[31:16];
			end
			if (hitWr(bus, `BCCS_OFF_DN_SPLIT)) begin
				dnLimit_r <= w[31:16];
			end
		end
	end

	bccs_split_check upCheck (
		.limit     (upLimit_r),
		.committed (upCommitted),
		.reqSize   (upReqSize),
		.reqValid  (upReqValid),
		.reqGo     (upReqGo),
		.reqDelay  (upDelay)
	);

	bccs_split_check dnCheck (
		.limit     (dnLimit_r),
		.committed (dnCommitted),
		.reqSize   (dnReqSize),
		.reqValid  (dnReqValid),
		.reqGo     (dnReqGo),
		.reqDelay  (dnDelay)
	);

	// Set wins over a same-cycle clear
	always_ff @(posedge clock) begin
		if (rst) begin
			splitDelayed_r <= 1'b0;
		end else if (upDelay | dnDelay) begin
			splitDelayed_r <= 1'b1;
		end else if (hitWr(bus, `BCCS_OFF_SPLIT_STAT) && w[`BCCS_BIT_SPLIT_DLY]) begin
			splitDelayed_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Power management
	// ----------------------------------------
	bccs_pkg::bccs_pm_e pmState_r;
	logic [7:0]         pmCount_r;
	logic               pmeEnable_r;
	logic               pmeStatus_r;
	logic [1:0]         pstateWr;
	logic               pmCsrWr;

	assign pmCsrWr  = hitWr(bus, `BCCS_OFF_PWR_CSR);
	assign pstateWr = w[1:0];

	always_ff @(posedge clock) begin
		if (rst) begin
			pmState_r <= bccs_pkg::PM_D0;
			pmCount_r <= 8'h00;
		end else begin
			case (pmState_r)
				bccs_pkg::PM_D0: begin
					if (pmCsrWr && pstateWr == `BCCS_PSTATE_D3) begin
						pmState_r <= bccs_pkg::PM_D3;
					end
				end
				bccs_pkg::PM_D3: begin
					if (pmCsrWr && pstateWr == `BCCS_PSTATE_D0) begin
						pmState_r <= bccs_pkg::PM_RESET;
						pmCount_r <= PM_RESET_CYC[7:0];
					end
				end
				bccs_pkg::PM_RESET: begin
					if (pmCount_r <= 8'h01) begin
						pmState_r <= bccs_pkg::PM_D0;
					end
					pmCount_r <= pmCount_r - 8'h01;
				end
				default: begin
					pmState_r <= bccs_pkg::PM_D0;
				end
			endcase
		end
	end

	// Sticky bits survive the soft reset, cleared only by rst
	always_ff @(posedge clock) begin
		if (rst) begin
			pmeEnable_r <= 1'b0;
		end else if (pmCsrWr) begin
			pmeEnable_r <= w[`BCCS_BIT_PME_EN];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pmeStatus_r <= 1'b0;
		end else if (pmeEventIn) begin
			pmeStatus_r <= 1'b1;
		end else if (pmCsrWr && w[`BCCS_BIT_PME_STAT]) begin
			pmeStatus_r <= 1'b0;
		end
	end

	logic pmeOut_r;
	always_ff @(posedge clock) begin
		if (rst) begin
			pmeOut_r <= 1'b0;
		end else begin
			pmeOut_r <= pmeStatus_r & pmeEnable_r;
		end
	end

	assign power_event_out_n = ~(pmeOut_r & pmeEnable_r);
	assign internalReset     = (pmState_r == bccs_pkg::PM_RESET);
	assign secBusReset       = 1'b0;

	logic [1:0] pstateRd;
	assign pstateRd = (pmState_r == bccs_pkg::PM_D3) ? `BCCS_PSTATE_D3 : `BCCS_PSTATE_D0;

	// ----------------------------------------
	// Slot identification and clock gating
	// ----------------------------------------
	logic [4:0]  slotNum_r;
	logic        firstInChassis_r;
	logic [7:0]  chassis_r;
	logic [10:0] gateCtl_r;
	logic        clkrunEn_r;
	logic        clkrunMode_r;
	logic        clockStop_r;
	logic        clockStop_nxt;

	always_ff @(posedge clock) begin
		if (rst || internalReset) begin
			slotNum_r        <= 5'h00;
			firstInChassis_r <= 1'b0;
			chassis_r        <= 8'h00;
		end else if (hitWr(bus, `BCCS_OFF_SLOT_ID)) begin
			slotNum_r        <= w[20:16];
			firstInChassis_r <= w[21];
			chassis_r        <= w[31:24];
		end
	end

	always_ff @(posedge clock) begin
		if (rst || internalReset) begin
			gateCtl_r    <= 11'h000;
			clkrunEn_r   <= 1'b0;
			clkrunMode_r <= 1'b0;
		end else if (hitWr(bus, `BCCS_OFF_CLK_GATE)) begin
			gateCtl_r    <= w[10:0];
			clkrunEn_r   <= w[`BCCS_BIT_CLKRUN_EN];
			clkrunMode_r <= w[`BCCS_BIT_CLKRUN_MODE];
		end
	end

	always_comb begin
		if (clkrunMode_r) begin
			clockStop_nxt = secIdle & ~priPending;
		end else begin
			clockStop_nxt = (pmState_r == bccs_pkg::PM_D3);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			clockStop_r <= 1'b0;
		end else begin
			clockStop_r <= clockStop_nxt;
		end
	end

	assign clkrunEnable = clkrunEn_r;

	logic [6:0] clkOuts;
	bccs_clock_gate clockGate (
		.clock       (clock),
		.rst         (rst),
		.clockIn     (secClockIn),
		.forwardMode (forwardMode),
		.gateCtl     (gateCtl_r),
		.clockStop   (clockStop_r),
		.clockOut    (clkOuts)
	);

	assign slot_clock_out_0          = clkOuts[0];
	assign slot_clock_out_1          = clkOuts[1];
	assign slot_clock_out_2          = clkOuts[2];
	assign slot_clock_out_3          = clkOuts[3];
	assign device_clock_out_1        = clkOuts[4];
	assign device_clock_out_2        = clkOuts[5];
	assign bridge_feedback_clock_out = clkOuts[6];

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	logic [31:0] rdNxt;
	logic [7:0]  subNext;
	logic [3:0]  portType;

	assign subNext  = slotIdEnable ? `BCCS_SUB_NEXT_SI : `BCCS_SUB_NEXT_DFLT;
	assign portType = forwardMode ? `BCCS_EXP_TYPE_FWD : `BCCS_EXP_TYPE_REV;

	always_comb begin
		rdNxt = 32'h0000_0000;
		case (bus.addr)
			`BCCS_OFF_UP_SPLIT:   rdNxt = {upLimit_r, `BCCS_SPLIT_CAP};
			`BCCS_OFF_DN_SPLIT:   rdNxt = {dnLimit_r, `BCCS_SPLIT_CAP};
			`BCCS_OFF_SPLIT_STAT: rdNxt = {10'h000, splitDelayed_r, 21'h000000};
			`BCCS_OFF_PWR_CAP:    rdNxt = {`BCCS_PME_SUPPORT, 2'b00, `BCCS_AUX_CURRENT, 1'b0, 1'b0, 1'b0,
			                               `BCCS_PM_VERSION, `BCCS_PM_NEXT, `BCCS_PM_ID};
			`BCCS_OFF_PWR_CSR:    rdNxt = {16'h0000, pmeStatus_r, 6'h00, pmeEnable_r, 6'h00, pstateRd};
			`BCCS_OFF_SLOT_ID:    rdNxt = {chassis_r, 2'b00, firstInChassis_r, slotNum_r, `BCCS_SI_NEXT, `BCCS_SI_ID};
			`BCCS_OFF_CLK_GATE:   rdNxt = {16'h0000, clkrunMode_r, clkrunEn_r, clockStop_r, 2'b00, gateCtl_r};
			`BCCS_OFF_SUBSYS_CAP: rdNxt = {16'h0000, subNext, `BCCS_SUB_ID};
			`BCCS_OFF_SUBSYS_ID:  rdNxt = {CARD_CODE, CARD_VENDOR_CODE};
			`BCCS_OFF_EXP_CAP:    rdNxt = {8'h00, portType, `BCCS_EXP_VERSION, `BCCS_EXP_NEXT, `BCCS_EXP_ID};
			default:              rdNxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (bus.rd) begin
			rdata <= rdNxt;
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

endmodule

// [test/bccs_regs_assertions.sv]
/*
 Checker for the bridge capability register bank, bound to its top module.
 Assumes one core clock, synchronous active-high reset and the bind below.
*/
`timescale 1ns/10ps

module bccs_regs_checker #(
	parameter int PM_RESET_CYC = 10
) (
	input wire logic                clock,
	input wire logic                rst,
	input wire bccs_pkg::bccs_bus_s bus,
	input wire logic [31:0]         rdata,
	input wire logic                forwardModePin,
	input wire logic                powerEvent,
	input wire logic                upReqValid,
	input wire logic [15:0]         upReqSize,
	input wire logic [15:0]         upCommitted,
	input wire logic                upReqGo,
	input wire logic                dnReqValid,
	input wire logic [15:0]         dnReqSize,
	input wire logic [15:0]         dnCommitted,
	input wire logic                dnReqGo,
	input wire logic                power_event_out_n,
	input wire logic                internalReset,
	input wire logic                secBusReset
);
	// ----------------
	// Shadow state
	// ----------------
	logic [15:0] upLim_r;
	logic [15:0] dnLim_r;
	logic        pmeEn_r;
	int          hiCnt_r;
	wire         d0Wr = bus.wr && bus.addr == 8'h94 && bus.wdata[1:0] == 2'b00;

	// Limits and enable survive the soft reset, so only rst restores them
	always_ff @(posedge clock) begin
		if (rst) begin
			upLim_r <= 16'h0010;
			dnLim_r <= 16'h0010;
			pmeEn_r <= 1'b0;
		end else if (bus.wr) begin
			if (bus.addr == 8'h88)
				upLim_r <= bus.wdata[31:16];
			if (bus.addr == 8'h8c)
				dnLim_r <= bus.wdata[31:16];
			if (bus.addr == 8'h94)
				pmeEn_r <= bus.wdata[8];
		end
	end

	always_ff @(posedge clock) begin
		if (rst || !internalReset)
			hiCnt_r <= 0;
		else
			hiCnt_r <= hiCnt_r + 1;
	end

	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence rdAt(logic [7:0] a);
		bus.rd && bus.addr == a;
	endsequence

	sequence eventHeld;
		(pmeEn_r && powerEvent) [*5];
	endsequence

	pmCapRead_a: assert property (rdAt(8'h90) |=> rdata == 32'hc843a801)
		else $error("power capability word wrong");
	expRead_a: assert property ($stable(forwardModePin) [*4] ##0 rdAt(8'hb0) |=>
		rdata == ($past(forwardModePin) ? 32'h0071f010 : 32'h0081f010)) else $error("express word wrong");
	rsvdRead_a: assert property (bus.rd && bus.addr[7:3] == 5'h13 |=> rdata == 32'h0)
		else $error("reserved word not zero");
	upGo_a: assert property (upReqGo == (upReqValid && (upLim_r == 16'hffff ||
		17'(upCommitted) + 17'(upReqSize) <= 17'(upLim_r)))) else $error("upstream go wrong");
	dnGo_a: assert property (dnReqGo == (dnReqValid && (dnLim_r == 16'hffff ||
		17'(dnCommitted) + 17'(dnReqSize) <= 17'(dnLim_r)))) else $error("downstream go wrong");
	busReset_a: assert property (!secBusReset)
		else $error("secondary reset asserted");
	softCause_a: assert property ($rose(internalReset) |-> $past(d0Wr) || $past(d0Wr, 2))
		else $error("soft reset without D0 write");
	softLen_a: assert property ($fell(internalReset) |-> hiCnt_r == PM_RESET_CYC)
		else $error("soft reset length wrong");
	pmeGate_a: assert property (!pmeEn_r |-> power_event_out_n)
		else $error("event output active while disabled");
	pmeRaise_a: assert property (eventHeld |-> ##[0:4] !power_event_out_n)
		else $error("event output not raised");
endmodule

bind bccs_regs bccs_regs_checker #(.PM_RESET_CYC(PM_RESET_CYC)) chk (
	.clock, .rst, .bus, .rdata, .forwardModePin, .powerEvent, .upReqValid, .upReqSize,
	.upCommitted, .upReqGo, .dnReqValid, .dnReqSize, .dnCommitted, .dnReqGo,
	.power_event_out_n, .internalReset, .secBusReset
);

// [test/tb_top.sv]
/*
 Self-checking bench for the bridge capability register bank.
 Assumes the core files are compiled first and the checker is bound.
*/
`timescale 1ns/10ps

module tb_top;
	logic                     clock = 1'b0;
	logic                     rst, forwardModePin, slotIdEnablePin, powerEvent;
	logic                     secClockIn = 1'b0;
	bccs_pkg::bccs_bus_s      bus;
	bccs_pkg::bccs_busstate_s busState;
	logic [31:0]              rdata, d;
	logic                     upReqValid, dnReqValid, upReqGo, dnReqGo;
	logic [15:0]              upReqSize, upCommitted, dnReqSize, dnCommitted, lim;
	logic                     slot_clock_out_0, slot_clock_out_1, slot_clock_out_2, slot_clock_out_3;
	logic                     device_clock_out_1, device_clock_out_2, bridge_feedback_clock_out;
	logic                     power_event_out_n, internalReset, secBusReset, clkrunEnable;
	logic [39:0]              expQ [$];
	logic [39:0]              note;
	logic                     rdSeen = 1'b0;
	int                       n_fail = 0, samples_checked = 0, cyc = 0, seed = 47;
	wire  [6:0]               outs = {bridge_feedback_clock_out, device_clock_out_2, device_clock_out_1,
		slot_clock_out_3, slot_clock_out_2, slot_clock_out_1, slot_clock_out_0};
	logic [7:0]               ra [12] = '{8'h88, 8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4,
		8'ha8, 8'hac, 8'hb0, 8'h00};
	logic [31:0]              rv [12] = '{32'h00100010, 32'h00100010, 32'hc843a801, 32'h0, 32'h0, 32'h0,
		32'h0000b004, 32'h0, 32'h0000b00d, 32'ha5a55a5a, 32'h0071f010, 32'h0};

	bccs_regs uut (.clock, .rst, .bus, .rdata, .forwardModePin, .slotIdEnablePin, .busState, .powerEvent,
		.upReqValid, .upReqSize, .upCommitted, .upReqGo, .dnReqValid, .dnReqSize, .dnCommitted, .dnReqGo,
		.secClockIn, .slot_clock_out_0, .slot_clock_out_1, .slot_clock_out_2, .slot_clock_out_3,
		.device_clock_out_1, .device_clock_out_2, .bridge_feedback_clock_out, .power_event_out_n,
		.internalReset, .secBusReset, .clkrunEnable);

	always #2 clock = ~clock;
	// Secondary clock as data, half the core rate
	always @(posedge clock) secClockIn <= ~secClockIn;

	// ----------------
	// Tasks
	// ----------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		if (expQ.size() != 0)
			n_fail++;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Strobes stay up until the next op or gap, so ops run back to back
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		bus <= '{a, v, 1'b1, 1'b0};
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		expQ.push_back({a, e});
	endtask

	task automatic gap(input int n);
		@(posedge clock);
		bus <= '0;
		repeat (n) @(posedge clock);
	endtask

	task automatic clkChk(input logic [6:0] en);
		gap(2);
		repeat (2) begin
			@(posedge clock);
			check("clocks", 32'(outs), 32'(en & {7{secClockIn}}));
		end
	endtask

	task automatic fin(input string nm);
		gap(3);
		$display("test %s done", nm);
	endtask

	function automatic logic goExp(logic v, logic [15:0] c, logic [15:0] s, logic [15:0] l);
		return v && (l == 16'hffff || 17'(c) + 17'(s) <= 17'(l));
	endfunction

	// Read-data monitor: oldest note pairs with the cycle after each read
	always @(posedge clock) begin
		if (rdSeen && expQ.size() > 0) begin
			note = expQ.pop_front();
			check($sformatf("rdata %h", note[39:32]), rdata, note[31:0]);
		end
		rdSeen <= bus.rd && !rst;
	end

	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ----------------
	// Scenarios
	// ----------------
	initial begin
		{rst, forwardModePin, slotIdEnablePin, powerEvent} = 4'b1100;
		bus = '0;
		busState = '0;
		{upReqValid, dnReqValid, upReqSize, upCommitted, dnReqSize, dnCommitted} = '0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		foreach (ra[i])
			rd(ra[i], rv[i]);
		foreach (ra[i])
			if (!(ra[i] inside {8'h88, 8'h8c, 8'h94, 8'ha0, 8'ha4}))
				wr(ra[i], 32'hffffffff);
		foreach (ra[i])
			rd(ra[i], rv[i]);
		fin("reset and read-only");
		repeat (3) begin
			d = $random(seed);
			wr(8'ha0, d);
			rd(8'ha0, {d[31:24], 2'b00, d[21:16], 16'hb004});
			wr(8'h88, d);
			rd(8'h88, {d[31:16], 16'h0010});
		end
		slotIdEnablePin <= 1'b1;
		gap(4);
		rd(8'ha8, 32'h0000a00d);
		slotIdEnablePin <= 1'b0;
		fin("writable fields");
		for (int j = 0; j < 3; j++) begin
			lim = (j == 0) ? 16'($random(seed) & 63) : (j == 1) ? 16'hffff : 16'h0010;
			wr(8'h88, {lim, 16'h0});
			wr(8'h8c, {lim, 16'h0});
			gap(1);
			repeat (8) begin
				upReqValid <= 1'($random(seed));
				dnReqValid <= 1'($random(seed));
				upReqSize <= 16'($random(seed) & 31);
				dnReqSize <= 16'($random(seed) & 31);
				upCommitted <= 16'($random(seed) & 31);
				dnCommitted <= 16'($random(seed) & 31);
				@(posedge clock);
				check("upGo", 32'(upReqGo), 32'(goExp(upReqValid, upCommitted, upReqSize, lim)));
				check("dnGo", 32'(dnReqGo), 32'(goExp(dnReqValid, dnCommitted, dnReqSize, lim)));
			end
		end
		upReqValid <= 1'b1;
		upCommitted <= 16'h0010;
		upReqSize <= 16'h0001;
		dnReqValid <= 1'b0;
		@(posedge clock);
		upReqValid <= 1'b0;
		gap(2);
		rd(8'h84, 32'h00200000);
		wr(8'h84, 32'h00200000);
		rd(8'h84, 32'h0);
		fin("commitment limits");
		wr(8'h94, 32'h1);
		wr(8'h94, 32'h2);
		rd(8'h94, 32'h0);
		wr(8'h94, 32'h103);
		rd(8'h94, 32'h103);
		wr(8'h94, 32'h101);
		rd(8'h94, 32'h103);
		gap(4);
		rd(8'ha4, 32'h2000);
		clkChk(7'h00);
		wr(8'ha0, 32'hff3f0000);
		wr(8'h94, 32'h100);
		gap(1);
		check("softRst", 32'(internalReset), 32'h1);
		for (int i = 0; i < 40 && internalReset !== 1'b0; i++) @(posedge clock);
		rd(8'h94, 32'h100);
		rd(8'ha0, 32'h0000b004);
		clkChk(7'h7f);
		fin("power states");
		wr(8'h94, 32'h0);
		powerEvent <= 1'b1;
		gap(6);
		check("pmeOut", 32'(power_event_out_n), 32'h1);
		rd(8'h94, 32'h8000);
		wr(8'h94, 32'h100);
		gap(0);
		for (int i = 0; i < 20 && power_event_out_n !== 1'b0; i++) @(posedge clock);
		check("pmeOut", 32'(power_event_out_n), 32'h0);
		// Keep the event up with enable set long enough for the raise check
		gap(4);
		powerEvent <= 1'b0;
		gap(4);
		wr(8'h94, 32'h8100);
		gap(3);
		check("pmeOut", 32'(power_event_out_n), 32'h1);
		rd(8'h94, 32'h100);
		fin("power events");
		for (int c = 0; c < 4; c++) begin
			d = {21'h0, {3{c[0]}}, {4{c[1:0]}}};
			wr(8'ha4, d);
			rd(8'ha4, d);
			clkChk({{3{!c[0]}}, {4{c != 3}}});
		end
		wr(8'ha4, 32'h4000);
		gap(2);
		check("clkrun", 32'(clkrunEnable), 32'h1);
		busState <= '{secIdle: 1'b1, priPending: 1'b0};
		wr(8'ha4, 32'h8000);
		gap(6);
		rd(8'ha4, 32'ha000);
		clkChk(7'h00);
		busState.priPending <= 1'b1;
		gap(6);
		rd(8'ha4, 32'h8000);
		clkChk(7'h7f);
		forwardModePin <= 1'b0;
		wr(8'ha4, 32'h7ff);
		gap(4);
		rd(8'hb0, 32'h0081f010);
		clkChk(7'h7f);
		forwardModePin <= 1'b1;
		wr(8'ha4, 32'h0);
		fin("clock gating");
		report_and_stop();
	end
endmodule
